// file: shared/timer_params.svh
// constants and field layout of the eight bit timer with pwm output
// Behaviour
// - counter clocked by clk, tick only enables
// - force strobe acts only in non-pwm modes
// - force applies match action with action field of the same write
// - force sets no flag, never clears counter
// - force strobe bit always reads zero
// - wave mode split over bits six and three
// - per mode top, compare update, overflow point
// - nonzero action field overrides port, direction enables
// - non-pwm actions: off, toggle, clear, set
// - fast pwm: off, reserved, clear/set, set/clear
// - phase pwm: up and down matches act oppositely
// - compare at top with high action: act at top
// - clock select: stop, div1..1024, pin edges
// - pin edges count even when pin is output
// - counter readable and writable any time
// - counter write blocks match on next tick
// - compare continuously, match sets flag, drives wave
// - overflow request needs enable, flag, global enable
// - overflow flag set on event, cleared ack/w1c
// - compare flag set on match, cleared ack/w1c
// - fast pwm counts bottom to max, wraps
// - phase pwm counts up, down, max once
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

`define BUS_ADDR_W      8
`define OFS_CONTROL     8'h00
`define OFS_COUNT       8'h04
`define OFS_COMPARE     8'h08
`define OFS_IRQ_MASK    8'h0C
`define OFS_IRQ_FLAGS   8'h10

`define BIT_FORCE       7
`define BIT_WAVE_LO     6
`define BIT_ACT_HI      5
`define BIT_ACT_LO      4
`define BIT_WAVE_HI     3
`define BIT_OVERFLOW    1
`define BIT_COMPARE     0

`define CONTROL_RESET   7'h00
`define COUNT_RESET     8'h00
`define COMPARE_RESET   8'h00
`define COUNT_MAX       8'hFF
`define COUNT_BOTTOM    8'h00

`define MODE_NORMAL     2'h0
`define MODE_PHASE      2'h1
`define MODE_CTC        2'h2
`define MODE_FAST       2'h3

`define ACT_OFF         2'h0
`define ACT_TOGGLE      2'h1
`define ACT_CLEAR       2'h2
`define ACT_SET         2'h3

`define CSEL_STOP       3'h0
`define CSEL_DIV1       3'h1
`define CSEL_DIV8       3'h2
`define CSEL_DIV64      3'h3
`define CSEL_DIV256     3'h4
`define CSEL_DIV1024    3'h5
`define CSEL_PIN_FALL   3'h6
`define CSEL_PIN_RISE   3'h7

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// file: shared/timer_pkg.sv
// types shared by the timer and its bus
package timer_pkg;
`include "timer_params.svh"

	typedef struct packed {
		logic                    awvalid;
		logic [`BUS_ADDR_W-1:0]  awaddr;
		logic                    wvalid;
		logic [31:0]             wdata;
		logic [3:0]              wstrb;
		logic                    bready;
		logic                    arvalid;
		logic [`BUS_ADDR_W-1:0]  araddr;
		logic                    rready;
	} axil_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_resp_type;

	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_type;

endpackage : timer_pkg

// file: hw/tick_select.sv
// timer tick source selection and external pin edge detect
`timescale 1ns/1ps
`include "timer_params.svh"
module tick_select #(
	parameter int TAPS = 4
) (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic [2:0]      count_clock_select,
	input  wire logic [TAPS-1:0] prescale_taps,
	input  wire logic            external_count_pin,
	output logic                 timer_tick_enable
);
	import timer_pkg::*;

	logic pin_prev_q;
	logic pin_rise;
	logic pin_fall;

	// edges seen whatever the pin direction
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= external_count_pin;
		end
	end

	assign pin_rise = external_count_pin & ~pin_prev_q;
	assign pin_fall = ~external_count_pin & pin_prev_q;

	always_comb begin
		unique case (count_clock_select)
			`CSEL_STOP:     timer_tick_enable = 1'b0;
			`CSEL_DIV1:     timer_tick_enable = 1'b1;
			`CSEL_DIV8:     timer_tick_enable = prescale_taps[0];
			`CSEL_DIV64:    timer_tick_enable = prescale_taps[1];
			`CSEL_DIV256:   timer_tick_enable = prescale_taps[2];
			`CSEL_DIV1024:  timer_tick_enable = prescale_taps[3];
			`CSEL_PIN_FALL: timer_tick_enable = pin_fall;
			`CSEL_PIN_RISE: timer_tick_enable = pin_rise;
		endcase
	end

endmodule : tick_select

// file: hw/timer_pwm_unit.sv
// eight bit timer with one compare channel and axi4-lite registers
`timescale 1ns/1ps
`include "timer_params.svh"
module timer_pwm_unit (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  timer_pkg::axil_req_type      bus_req,
	output timer_pkg::axil_resp_type     bus_resp,
	input  wire logic [3:0]              prescale_taps,
	input  wire logic                    external_count_pin,
	input  wire logic                    global_irq_enable,
	input  wire logic                    overflow_vector_ack,
	input  wire logic                    compare_vector_ack,
	input  wire logic                    wave_pin_dir,
	input  wire logic                    port_data,
	output timer_pkg::pin_drive_type     wave_pin,
	output logic                         overflow_irq,
	output logic                         compare_irq
);
	import timer_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// bus slave state

	logic                   awready_q;
	logic                   wready_q;
	logic                   bvalid_q;
	logic [1:0]             bresp_q;
	logic                   arready_q;
	logic                   rvalid_q;
	logic [31:0]            rdata_q;
	logic [1:0]             rresp_q;
	logic                   aw_full_q;
	logic                   w_full_q;
	logic [`BUS_ADDR_W-1:0] waddr_q;
	logic [7:0]             wbyte_q;
	logic                   wlane_q;

	logic                   aw_take;
	logic                   w_take;
	logic                   ar_take;
	logic                   do_write;
	logic                   aw_full_d;
	logic                   w_full_d;
	logic                   bvalid_d;
	logic                   rvalid_d;
	logic                   wr_hit;
	logic                   rd_hit;
	logic [7:0]             rd_byte;

	////////////////////////////////////////////////////////////////////////
	// timer state

	logic [6:0] control_q;
	logic [7:0] count_q;
	logic [7:0] compare_buf_q;
	logic [7:0] compare_act_q;
	logic       count_up_q;
	logic       block_q;
	logic       wave_q;
	logic [1:0] irq_mask_q;
	logic       overflow_flag_q;
	logic       compare_flag_q;
	logic       pin_out_q;
	logic       pin_oe_q;
	logic       overflow_irq_q;
	logic       compare_irq_q;

	logic [7:0] count_d;
	logic [7:0] compare_buf_d;
	logic [7:0] compare_act_d;
	logic       count_up_d;
	logic       wave_d;
	logic       overflow_flag_d;
	logic       compare_flag_d;

	logic       tick;
	logic [1:0] mode;
	logic [1:0] act;
	logic       is_pwm;
	logic       at_max;
	logic       at_bottom;
	logic       match_raw;
	logic       match;
	logic       top_tick;
	logic       top_special;
	logic       overflow_event;
	logic       wr_control;
	logic       wr_count;
	logic       wr_compare;
	logic       wr_mask;
	logic       wr_flags;
	logic [1:0] new_mode;
	logic [1:0] new_act;
	logic       force_hit;

	////////////////////////////////////////////////////////////////////////
	// bus handshakes

	assign aw_take   = bus_req.awvalid & awready_q;
	assign w_take    = bus_req.wvalid & wready_q;
	assign ar_take   = bus_req.arvalid & arready_q;
	assign do_write  = aw_full_q & w_full_q & ~bvalid_q;
	assign aw_full_d = do_write ? 1'b0 : (aw_full_q | aw_take);
	assign w_full_d  = do_write ? 1'b0 : (w_full_q | w_take);
	assign bvalid_d  = do_write | (bvalid_q & ~bus_req.bready);
	assign rvalid_d  = ar_take | (rvalid_q & ~bus_req.rready);

	assign wr_hit = (waddr_q == `OFS_CONTROL) | (waddr_q == `OFS_COUNT)
		| (waddr_q == `OFS_COMPARE) | (waddr_q == `OFS_IRQ_MASK)
		| (waddr_q == `OFS_IRQ_FLAGS);
	assign rd_hit = (bus_req.araddr == `OFS_CONTROL) | (bus_req.araddr == `OFS_COUNT)
		| (bus_req.araddr == `OFS_COMPARE) | (bus_req.araddr == `OFS_IRQ_MASK)
		| (bus_req.araddr == `OFS_IRQ_FLAGS);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			waddr_q   <= '0;
			wbyte_q   <= 8'h00;
			wlane_q   <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			if (aw_take) begin
				waddr_q <= bus_req.awaddr;
			end
			if (w_take) begin
				wbyte_q <= bus_req.wdata[7:0];
				wlane_q <= bus_req.wstrb[0];
			end
			awready_q <= ~aw_full_d & ~bvalid_d;
			wready_q  <= ~w_full_d & ~bvalid_d;
			bvalid_q  <= bvalid_d;
			if (do_write) begin
				bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= `RESP_OKAY;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_take) begin
				rdata_q <= {24'h00_0000, rd_byte};
				rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// read mux, force strobe never stored
	always_comb begin
		unique case (bus_req.araddr)
			`OFS_CONTROL:   rd_byte = {1'b0, control_q};
			`OFS_COUNT:     rd_byte = count_q;
			`OFS_COMPARE:   rd_byte = compare_buf_q;
			`OFS_IRQ_MASK:  rd_byte = {6'h00, irq_mask_q};
			`OFS_IRQ_FLAGS: rd_byte = {6'h00, overflow_flag_q, compare_flag_q};
			default:        rd_byte = 8'h00;
		endcase
	end

	assign bus_resp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
		bresp: bresp_q, arready: arready_q, rvalid: rvalid_q, rdata: rdata_q,
		rresp: rresp_q};

	////////////////////////////////////////////////////////////////////////
	// register write decode

	assign wr_control = do_write & wlane_q & (waddr_q == `OFS_CONTROL);
	assign wr_count   = do_write & wlane_q & (waddr_q == `OFS_COUNT);
	assign wr_compare = do_write & wlane_q & (waddr_q == `OFS_COMPARE);
	assign wr_mask    = do_write & wlane_q & (waddr_q == `OFS_IRQ_MASK);
	assign wr_flags   = do_write & wlane_q & (waddr_q == `OFS_IRQ_FLAGS);

	assign new_mode  = {wbyte_q[`BIT_WAVE_HI], wbyte_q[`BIT_WAVE_LO]};
	assign new_act   = wbyte_q[`BIT_ACT_HI:`BIT_ACT_LO];
	assign force_hit = wr_control & wbyte_q[`BIT_FORCE] & ~new_mode[0];

	////////////////////////////////////////////////////////////////////////
	// tick source

	tick_select #(
		.TAPS(4)
	) tick_select_inst (
		.clk                (clk),
		.rst                (rst),
		.count_clock_select (control_q[2:0]),
		.prescale_taps      (prescale_taps),
		.external_count_pin (external_count_pin),
		.timer_tick_enable  (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// count and compare decode

	assign mode        = {control_q[`BIT_WAVE_HI], control_q[`BIT_WAVE_LO]};
	assign act         = control_q[`BIT_ACT_HI:`BIT_ACT_LO];
	assign is_pwm      = mode[0];
	assign at_max      = (count_q == `COUNT_MAX);
	assign at_bottom   = (count_q == `COUNT_BOTTOM);
	assign match_raw   = (count_q == compare_act_q);
	assign match       = tick & match_raw & ~block_q;
	assign top_tick    = tick & at_max & is_pwm;
	assign top_special = act[1] & (compare_act_q == `COUNT_MAX);

	// overflow at max, phase mode at bottom turning up
	assign overflow_event = (mode == `MODE_PHASE)
		? (tick & ~count_up_q & at_bottom)
		: (tick & at_max);

	// next count
	always_comb begin
		count_d    = count_q;
		count_up_d = count_up_q;
		if (wr_count) begin
			count_d = wbyte_q;
		end else if (tick) begin
			unique case (mode)
				`MODE_NORMAL: count_d = count_q + 8'h01;
				`MODE_FAST:   count_d = count_q + 8'h01;
				`MODE_CTC:    count_d = match ? `COUNT_BOTTOM : (count_q + 8'h01);
				`MODE_PHASE: begin
					if (count_up_q) begin
						count_d    = at_max ? (count_q - 8'h01) : (count_q + 8'h01);
						count_up_d = ~at_max;
					end else begin
						count_d    = at_bottom ? (count_q + 8'h01) : (count_q - 8'h01);
						count_up_d = at_bottom;
					end
				end
			endcase
		end
		if (mode != `MODE_PHASE) begin
			count_up_d = 1'b1;
		end
	end

	// compare buffer, loaded at top in pwm modes
	assign compare_buf_d = wr_compare ? wbyte_q : compare_buf_q;
	assign compare_act_d = (~is_pwm | top_tick) ? compare_buf_d : compare_act_q;

	// flags, a set wins over a clear
	assign overflow_flag_d = overflow_event
		| (overflow_flag_q & ~overflow_vector_ack
		& ~(wr_flags & wbyte_q[`BIT_OVERFLOW]));
	assign compare_flag_d = match
		| (compare_flag_q & ~compare_vector_ack
		& ~(wr_flags & wbyte_q[`BIT_COMPARE]));

	////////////////////////////////////////////////////////////////////////
	// waveform generator

	always_comb begin
		wave_d = wave_q;
		unique case (mode)
			`MODE_NORMAL, `MODE_CTC: begin
				if (match) begin
					unique case (act)
						`ACT_OFF:    wave_d = wave_q;
						`ACT_TOGGLE: wave_d = ~wave_q;
						`ACT_CLEAR:  wave_d = 1'b0;
						`ACT_SET:    wave_d = 1'b1;
					endcase
				end
			end
			`MODE_FAST: begin
				if (act[1]) begin
					if (match & ~top_special) begin
						wave_d = act[0];
					end
					if (tick & at_max) begin
						wave_d = ~act[0];
					end
				end
			end
			`MODE_PHASE: begin
				if (act[1]) begin
					if (match & ~top_special) begin
						wave_d = count_up_q ? act[0] : ~act[0];
					end
					if (top_special & tick & at_max) begin
						wave_d = ~act[0];
					end
				end
			end
		endcase
		if (force_hit) begin
			unique case (new_act)
				`ACT_OFF:    wave_d = wave_q;
				`ACT_TOGGLE: wave_d = ~wave_q;
				`ACT_CLEAR:  wave_d = 1'b0;
				`ACT_SET:    wave_d = 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timer registers

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			control_q     <= `CONTROL_RESET;
			count_q       <= `COUNT_RESET;
			compare_buf_q <= `COMPARE_RESET;
			compare_act_q <= `COMPARE_RESET;
			count_up_q    <= 1'b1;
			block_q       <= 1'b0;
			wave_q        <= 1'b0;
		end else begin
			if (wr_control) begin
				control_q <= wbyte_q[6:0];
			end
			count_q       <= count_d;
			compare_buf_q <= compare_buf_d;
			compare_act_q <= compare_act_d;
			count_up_q    <= count_up_d;
			block_q       <= wr_count | (block_q & ~tick);
			wave_q        <= wave_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_mask_q      <= 2'h0;
			overflow_flag_q <= 1'b0;
			compare_flag_q  <= 1'b0;
			overflow_irq_q  <= 1'b0;
			compare_irq_q   <= 1'b0;
		end else begin
			if (wr_mask) begin
				irq_mask_q <= wbyte_q[1:0];
			end
			overflow_flag_q <= overflow_flag_d;
			compare_flag_q  <= compare_flag_d;
			overflow_irq_q  <= overflow_flag_d & irq_mask_q[`BIT_OVERFLOW] & global_irq_enable;
			compare_irq_q   <= compare_flag_d & irq_mask_q[`BIT_COMPARE] & global_irq_enable;
		end
	end

	assign overflow_irq = overflow_irq_q;
	assign compare_irq  = compare_irq_q;

	////////////////////////////////////////////////////////////////////////
	// pin override

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out_q <= 1'b0;
			pin_oe_q  <= 1'b0;
		end else begin
			pin_out_q <= (|act) ? wave_d : port_data;
			pin_oe_q  <= wave_pin_dir;
		end
	end

	assign wave_pin = '{out: pin_out_q, oe: pin_oe_q};

endmodule : timer_pwm_unit

// file: sim/timer_pwm_unit_checker.sv
// port assertions for the timer with pwm output
`timescale 1ns/1ps
module timer_pwm_unit_checker (
	input  wire logic               clk,
	input  wire logic               rst,
	input  timer_pkg::axil_req_type  bus_req,
	input  timer_pkg::axil_resp_type bus_resp,
	input  wire logic [3:0]         prescale_taps,
	input  wire logic               external_count_pin,
	input  wire logic               global_irq_enable,
	input  wire logic               overflow_vector_ack,
	input  wire logic               compare_vector_ack,
	input  wire logic               wave_pin_dir,
	input  wire logic               port_data,
	input  timer_pkg::pin_drive_type wave_pin,
	input  wire logic               overflow_irq,
	input  wire logic               compare_irq
);
	import timer_pkg::*;
	logic touched_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// set once control has been written
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			touched_q <= 1'b0;
		end else if (bus_req.awvalid && bus_resp.awready && bus_req.awaddr == 8'h00) begin
			touched_q <= 1'b1;
		end
	end
	////////////////////////////////////////////////
	pin_enable_a: assert property (
		!$past(rst) |-> wave_pin.oe == $past(wave_pin_dir))
		else $error("pin enable not following direction");
	port_follow_a: assert property (
		!touched_q && !$past(rst) |-> wave_pin.out == $past(port_data))
		else $error("pin not passing port data after reset");
	ovf_irq_gate_a: assert property (
		overflow_irq |-> $past(global_irq_enable))
		else $error("overflow request without global enable");
	cmp_irq_gate_a: assert property (
		!global_irq_enable |=> !compare_irq)
		else $error("compare request without global enable");
	write_busy_a: assert property (
		bus_resp.bvalid |-> !bus_resp.awready && !bus_resp.wready)
		else $error("write accepted while response pending");
	write_answer_a: assert property (
		bus_req.awvalid && bus_resp.awready && bus_req.wvalid && bus_resp.wready |-> ##2 bus_resp.bvalid)
		else $error("write response late");
	read_answer_a: assert property (
		bus_req.arvalid && bus_resp.arready |=> bus_resp.rvalid && !bus_resp.arready)
		else $error("read response late");
	read_width_a: assert property (
		bus_resp.rvalid |-> bus_resp.rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	cover property ($rose(overflow_irq));
	cover property (touched_q && $rose(wave_pin.out));
	cover property (bus_resp.rvalid && bus_resp.rresp == 2'h2);
endmodule : timer_pwm_unit_checker

bind timer_pwm_unit timer_pwm_unit_checker timer_pwm_unit_checker_inst (.clk(clk), .rst(rst),
	.bus_req(bus_req), .bus_resp(bus_resp), .prescale_taps(prescale_taps),
	.external_count_pin(external_count_pin), .global_irq_enable(global_irq_enable),
	.overflow_vector_ack(overflow_vector_ack), .compare_vector_ack(compare_vector_ack),
	.wave_pin_dir(wave_pin_dir), .port_data(port_data), .wave_pin(wave_pin),
	.overflow_irq(overflow_irq), .compare_irq(compare_irq));

// file: sim/timer_pwm_unit_tb.sv
// self-checking bench for the timer with pwm output
`timescale 1ns/1ps
`include "timer_params.svh"
module timer_pwm_unit_tb;
	import timer_pkg::*;
	logic          clk, rst, ext_pin, glob, ovf_ack, cmp_ack, dir, pdata, ovf_irq, cmp_irq;
	logic [3:0]    taps;
	axil_req_type  req;
	axil_resp_type resp;
	pin_drive_type pin;
	logic [31:0]   rd;
	logic [1:0]    rr;
	int            miscompares, checks_done;

	timer_pwm_unit timer_pwm_unit_inst (.clk(clk), .rst(rst), .bus_req(req), .bus_resp(resp),
		.prescale_taps(taps), .external_count_pin(ext_pin), .global_irq_enable(glob),
		.overflow_vector_ack(ovf_ack), .compare_vector_ack(cmp_ack), .wave_pin_dir(dir),
		.port_data(pdata), .wave_pin(pin), .overflow_irq(ovf_irq), .compare_irq(cmp_irq));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////
	function automatic logic [7:0] ctl(input logic f, input logic [1:0] m, input logic [1:0] a,
		input logic [2:0] s);
		return {f, m[0], a, m[1], s};
	endfunction : ctl

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= {24'h0, d};
		do begin
			@(posedge clk);
			if (resp.awready) req.awvalid <= 1'b0;
			if (resp.wready) req.wvalid <= 1'b0;
		end while (!resp.bvalid);
		chk(resp.bresp, `RESP_OKAY, "write resp");
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		do begin
			@(posedge clk);
			if (resp.arready) req.arvalid <= 1'b0;
		end while (!resp.rvalid);
		rd = resp.rdata;
		rr = resp.rresp;
	endtask : rdr

	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
		rdr(a);
		chk(rd, {24'h0, e}, m);
	endtask : rdc

	task automatic tick(input int n, input int b);
		repeat (n) begin
			taps[b] <= 1'b1;
			@(posedge clk);
			taps <= 4'h0;
			@(posedge clk);
		end
	endtask : tick

	task automatic settle;
		repeat (3) @(posedge clk);
	endtask : settle
	////////////////////////////////////////////////
	task automatic t_reset;
		rdc(`OFS_CONTROL, 8'h00, "control reset");
		rdc(`OFS_IRQ_FLAGS, 8'h00, "flags reset");
		pdata <= 1'b1;
		settle;
		chk(pin.out, 1, "port data");
		rdr(8'h14);
		chk(rr, `RESP_SLVERR, "unmapped resp");
		chk(rd, 0, "unmapped data");
	endtask : t_reset

	task automatic t_overflow;
		wr(`OFS_COUNT, 8'hFE);
		wr(`OFS_CONTROL, ctl(0, `MODE_NORMAL, `ACT_OFF, `CSEL_DIV8));
		tick(1, 0);
		rdc(`OFS_IRQ_FLAGS, 8'h00, "early overflow");
		tick(1, 0);
		rdc(`OFS_COUNT, 8'h00, "wrap");
		rdc(`OFS_IRQ_FLAGS, 8'h02, "overflow flag");
		wr(`OFS_IRQ_FLAGS, 8'h02);
		rdc(`OFS_IRQ_FLAGS, 8'h00, "write one clear");
	endtask : t_overflow

	task automatic t_ctc;
		wr(`OFS_COMPARE, 8'h03);
		wr(`OFS_CONTROL, ctl(0, `MODE_CTC, `ACT_OFF, `CSEL_DIV8));
		tick(3, 0);
		rdc(`OFS_COUNT, 8'h03, "count up");
		tick(1, 0);
		rdc(`OFS_COUNT, 8'h00, "clear on match");
		rdc(`OFS_IRQ_FLAGS, 8'h01, "compare flag");
		cmp_ack <= 1'b1;
		@(posedge clk);
		cmp_ack <= 1'b0;
		settle;
		rdc(`OFS_IRQ_FLAGS, 8'h00, "ack clear");
		wr(`OFS_COUNT, 8'h03);
		tick(1, 0);
		rdc(`OFS_COUNT, 8'h04, "blocked match");
		rdc(`OFS_IRQ_FLAGS, 8'h00, "blocked flag");
	endtask : t_ctc

	task automatic t_force;
		dir <= 1'b1;
		pdata <= 1'b0;
		wr(`OFS_COUNT, 8'h05);
		wr(`OFS_CONTROL, ctl(1, `MODE_CTC, `ACT_SET, `CSEL_STOP));
		settle;
		chk(pin.out, 1, "force set");
		chk(pin.oe, 1, "pin driven");
		wr(`OFS_CONTROL, ctl(1, `MODE_CTC, `ACT_CLEAR, `CSEL_STOP));
		settle;
		chk(pin.out, 0, "force clear");
		wr(`OFS_CONTROL, ctl(1, `MODE_NORMAL, `ACT_TOGGLE, `CSEL_STOP));
		settle;
		chk(pin.out, 1, "force toggle");
		rdc(`OFS_CONTROL, ctl(0, `MODE_NORMAL, `ACT_TOGGLE, `CSEL_STOP), "strobe read");
		rdc(`OFS_COUNT, 8'h05, "force count");
		rdc(`OFS_IRQ_FLAGS, 8'h00, "force flag");
		wr(`OFS_CONTROL, ctl(1, `MODE_FAST, `ACT_CLEAR, `CSEL_STOP));
		settle;
		chk(pin.out, 1, "force in pwm");
	endtask : t_force

	task automatic t_fast;
		wr(`OFS_COUNT, 8'h00);
		wr(`OFS_CONTROL, ctl(0, `MODE_FAST, `ACT_CLEAR, `CSEL_DIV8));
		tick(1, 0);
		wr(`OFS_COMPARE, 8'h80);
		rdc(`OFS_COMPARE, 8'h80, "compare buffer");
		tick(3, 0);
		chk(pin.out, 0, "fast clear");
		tick(251, 0);
		rdc(`OFS_IRQ_FLAGS, 8'h01, "fast before max");
		tick(1, 0);
		rdc(`OFS_COUNT, 8'h00, "fast restart");
		rdc(`OFS_IRQ_FLAGS, 8'h03, "fast overflow");
		chk(pin.out, 1, "fast top set");
		tick(4, 0);
		chk(pin.out, 1, "new compare");
		wr(`OFS_IRQ_FLAGS, 8'h03);
	endtask : t_fast

	task automatic t_phase;
		wr(`OFS_COUNT, 8'h00);
		wr(`OFS_CONTROL, ctl(0, `MODE_PHASE, `ACT_CLEAR, `CSEL_DIV8));
		tick(8'h81, 0);
		chk(pin.out, 0, "phase up match");
		tick(8'h7F, 0);
		rdc(`OFS_COUNT, 8'hFE, "phase turn");
		rdc(`OFS_IRQ_FLAGS, 8'h01, "phase no top flag");
		tick(8'h7E, 0);
		chk(pin.out, 0, "phase hold");
		tick(1, 0);
		chk(pin.out, 1, "phase down match");
	endtask : t_phase

	task automatic t_sources;
		wr(`OFS_CONTROL, 8'h00);
		wr(`OFS_COUNT, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_CONTROL, ctl(0, `MODE_NORMAL, `ACT_OFF, 3'(i + 2)));
			for (int j = 0; j < 4; j++) if (j != i) tick(1, j);
			tick(1, i);
			rdc(`OFS_COUNT, 8'(i + 1), "tap select");
		end
		wr(`OFS_CONTROL, ctl(0, `MODE_NORMAL, `ACT_OFF, `CSEL_PIN_RISE));
		ext_pin <= 1'b1;
		settle;
		rdc(`OFS_COUNT, 8'h05, "rising edge");
		wr(`OFS_CONTROL, ctl(0, `MODE_NORMAL, `ACT_OFF, `CSEL_PIN_FALL));
		ext_pin <= 1'b0;
		settle;
		rdc(`OFS_COUNT, 8'h06, "falling edge");
		wr(`OFS_CONTROL, ctl(0, `MODE_NORMAL, `ACT_OFF, `CSEL_DIV1));
		wr(`OFS_CONTROL, 8'h00);
		rdr(`OFS_COUNT);
		chk(rd, 32'h0000_0009, "clock counts");
	endtask : t_sources

	task automatic t_irq;
		wr(`OFS_IRQ_MASK, 8'h02);
		wr(`OFS_COUNT, 8'hFF);
		wr(`OFS_CONTROL, ctl(0, `MODE_NORMAL, `ACT_OFF, `CSEL_DIV8));
		tick(1, 0);
		settle;
		chk(ovf_irq, 0, "global off");
		glob <= 1'b1;
		settle;
		chk(ovf_irq, 1, "overflow request");
		chk(cmp_irq, 0, "compare masked");
		ovf_ack <= 1'b1;
		@(posedge clk);
		ovf_ack <= 1'b0;
		settle;
		chk(ovf_irq, 0, "ack");
		wr(`OFS_IRQ_MASK, 8'h03);
		settle;
		chk(cmp_irq, 1, "compare request");
	endtask : t_irq

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////
	initial begin
		req = '0;
		req.wstrb = 4'hF;
		req.bready = 1'b1;
		req.rready = 1'b1;
		{taps, ext_pin, glob, ovf_ack, cmp_ack, dir, pdata} = '0;
		miscompares = 0;
		checks_done = 0;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_overflow;
		t_ctc;
		t_force;
		t_fast;
		t_phase;
		t_sources;
		t_irq;
		stop_test;
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		stop_test;
	end
endmodule : timer_pwm_unit_tb
